// file: timer_pkg.sv
// Shared constants, types and helpers for the two-channel capture/compare timer.
// Assumes every user of it names items as timer_pkg::name.
package timer_pkg;

  localparam int unsigned CNT_W = 16;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CNT_STEP = 16'h0001;

  // Word offsets of the register words in the processor map.
  localparam logic [15:0] OFS_TIMER_CONTROL_WORD = 16'h0160;
  localparam logic [15:0] OFS_CHAN0_CONTROL_WORD = 16'h0162;
  localparam logic [15:0] OFS_CHAN1_CONTROL_WORD = 16'h0164;
  localparam logic [15:0] OFS_COUNTER_VALUE_WORD = 16'h0170;
  localparam logic [15:0] OFS_CHAN0_VALUE_WORD = 16'h0172;
  localparam logic [15:0] OFS_CHAN1_VALUE_WORD = 16'h0174;
  localparam logic [15:0] OFS_TIMER_VECTOR_WORD = 16'h012e;

  // Interrupt vector addresses: channel zero alone, channel one shares with overflow.
  localparam logic [15:0] VEC_ADDR_CHANNEL_ZERO = 16'hfff2;
  localparam logic [15:0] VEC_ADDR_SHARED = 16'hfff0;

  // Codes read from the vector word, highest priority first.
  localparam logic [3:0] VEC_NONE = 4'h0;
  localparam logic [3:0] VEC_CHANNEL_ONE = 4'h2;
  localparam logic [3:0] VEC_OVERFLOW = 4'ha;

  typedef enum logic [1:0] {
    CLK_EXT_PIN = 2'h0,
    CLK_AUX = 2'h1,
    CLK_SUBMAIN = 2'h2,
    CLK_ALTERNATE = 2'h3
  } clock_sel_t;

  typedef enum logic [1:0] {
    IN_A = 2'h0,
    IN_B = 2'h1,
    IN_GND = 2'h2,
    IN_VCC = 2'h3
  } input_sel_t;

  typedef enum logic [1:0] {
    EDGE_NONE = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_FALL = 2'h2,
    EDGE_BOTH = 2'h3
  } edge_sel_t;

  // True when the sampled level pair shows an edge of the chosen kind.
  function automatic logic edge_hit(input logic prev, input logic cur, input edge_sel_t sel);
    logic rise;
    logic fall;
    rise = ~prev & cur;
    fall = prev & ~cur;
    unique case (sel)
      EDGE_NONE: edge_hit = 1'b0;
      EDGE_RISE: edge_hit = rise;
      EDGE_FALL: edge_hit = fall;
      EDGE_BOTH: edge_hit = rise | fall;
    endcase
  endfunction

endpackage

// file: capture_compare_channel.sv
// One capture/compare channel: value word, event flag and output signal.
// Assumes the counter, its step and its wrap pulse come from the timer core clock.
`timescale 1ns/1ps
module capture_compare_channel (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic capture_mode,
  input wire timer_pkg::input_sel_t input_select,
  input wire timer_pkg::edge_sel_t capture_edge,
  input wire logic pwm_mode,
  input wire logic value_load,
  input wire logic [15:0] value_data,
  input wire logic flag_clear,
  input wire logic [15:0] counter,
  input wire logic counter_step,
  input wire logic counter_wrap,
  input wire logic input_a,
  input wire logic input_b,
  output logic [15:0] value_q,
  output logic flag_q,
  output logic overrun_q,
  output logic signal_q
);

  logic sel_level;
  logic sel_prev_q;
  logic capture_hit;
  logic compare_hit;
  logic event_hit;

  always_comb begin
    unique case (input_select)
      timer_pkg::IN_A: sel_level = input_a;
      timer_pkg::IN_B: sel_level = input_b;
      timer_pkg::IN_GND: sel_level = 1'b0;
      timer_pkg::IN_VCC: sel_level = 1'b1;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sel_prev_q <= 1'b0;
    end else begin
      sel_prev_q <= sel_level;
    end
  end

  assign capture_hit = capture_mode & timer_pkg::edge_hit(sel_prev_q, sel_level, capture_edge);
  assign compare_hit = ~capture_mode & counter_step & (counter == value_q);
  assign event_hit = capture_hit | compare_hit;

  // Capture latches the counter; otherwise software may load a compare value.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      value_q <= timer_pkg::CNT_RESET;
    end else if (capture_hit) begin
      value_q <= counter; // [R10]
    end else if (value_load) begin
      value_q <= value_data;
    end
  end

  // A new event in the clearing cycle keeps the flag set.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      flag_q <= 1'b0;
    end else if (event_hit) begin
      flag_q <= 1'b1; // [R10] [R03]
    end else if (flag_clear) begin
      flag_q <= 1'b0;
    end
  end

  // A capture while the flag is still pending marks a lost reading.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      overrun_q <= 1'b0;
    end else if (capture_hit & flag_q & ~flag_clear) begin
      overrun_q <= 1'b1;
    end else if (flag_clear) begin
      overrun_q <= 1'b0;
    end
  end

  // PWM mode sets at wrap and resets at match; otherwise each match toggles.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      signal_q <= 1'b0;
    end else if (pwm_mode) begin
      if (compare_hit) begin
        signal_q <= 1'b0; // [R07]
      end else if (counter_wrap) begin
        signal_q <= 1'b1; // [R07]
      end
    end else if (compare_hit) begin
      signal_q <= ~signal_q; // [R07]
    end
  end

endmodule

// file: timer_two_channel_capture.sv
// Top of the 16-bit timer with two capture/compare channels.
// Assumes all pin and clock-source levels are synchronous to core_clk and slower than it.
//
// How it works
// (R01) A 16-bit counter wraps through its full range; two channels watch it.
// (R02) Counter overflow sets a sticky flag that can request an interrupt.
// (R03) Each channel sets its own flag and may request an interrupt under its own enable bit.
// (R04) Count clock: external pin, auxiliary, sub-main, or alternate input from same pin.
// (R05) Channel zero captures from its pin, auxiliary clock, ground or supply.
// (R06) Channel one input B is comparator output or the second channel pin, by variant.
// (R07) Each channel drives a PWM-capable output; channels work independently.
// (R08) Channel zero has its own interrupt; channel one and overflow share one vector.
// (R09) Register words sit at fixed offsets; the vector word identifies the source.
// (R10) Compare flags on counter match; capture latches counter on chosen edge.
`timescale 1ns/1ps
module timer_two_channel_capture (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ext_timer_clock_pin,
  input wire logic aux_clock,
  input wire logic submain_clock,
  input wire timer_pkg::clock_sel_t clock_select,
  input wire logic count_run,
  input wire logic counter_clear,
  input wire logic overflow_irq_enable,
  input wire logic overflow_flag_clear,
  input wire logic comparator_variant,
  input wire logic channel0_signal_in,
  input wire logic channel1_signal_in,
  input wire logic channel1_signal_alt_in,
  input wire logic comparator_output,
  input wire logic [1:0] chan_capture_mode,
  input wire timer_pkg::input_sel_t chan0_input_select,
  input wire timer_pkg::input_sel_t chan1_input_select,
  input wire timer_pkg::edge_sel_t chan0_capture_edge,
  input wire timer_pkg::edge_sel_t chan1_capture_edge,
  input wire logic [1:0] chan_pwm_mode,
  input wire logic [1:0] chan_value_load,
  input wire logic [15:0] chan_value_data,
  input wire logic [1:0] chan_irq_enable,
  input wire logic [1:0] chan_flag_clear,
  input wire logic vector_read,
  output logic [15:0] counter_value_word_q,
  output logic [15:0] chan0_value_word_q,
  output logic [15:0] chan1_value_word_q,
  output logic counter_overflow_flag_q,
  output logic [1:0] channel_event_flag_q,
  output logic [1:0] capture_overrun_q,
  output logic channel0_signal_q,
  output logic channel1_signal_q,
  output logic channel_zero_irq_q,
  output logic shared_irq_q,
  output logic [3:0] timer_vector_word_q
);

  ////////////////////////////////////////////////////////////////////////////
  // Count clock selection and edge detection.

  logic src_level;
  logic src_prev_q;
  logic tick;
  logic step_q;
  logic wrap_q;
  logic overflow_hit;
  logic vec_is_ovf;

  always_comb begin
    unique case (clock_select)
      timer_pkg::CLK_EXT_PIN: src_level = ext_timer_clock_pin; // [R04]
      timer_pkg::CLK_AUX: src_level = aux_clock; // [R04]
      timer_pkg::CLK_SUBMAIN: src_level = submain_clock; // [R04]
      timer_pkg::CLK_ALTERNATE: src_level = ext_timer_clock_pin; // [R04]
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      src_prev_q <= 1'b0;
    end else begin
      src_prev_q <= src_level;
    end
  end

  assign tick = count_run & timer_pkg::edge_hit(src_prev_q, src_level, timer_pkg::EDGE_RISE);
  assign overflow_hit = tick & ~counter_clear & (counter_value_word_q == timer_pkg::CNT_MAX);

  ////////////////////////////////////////////////////////////////////////////
  // Counter.

  logic [15:0] counter_d;

  // A clear wins over a tick in the same cycle, so a cleared counter never shows one.
  always_comb begin
    if (counter_clear) begin
      counter_d = timer_pkg::CNT_RESET;
    end else if (tick) begin
      counter_d = counter_value_word_q + timer_pkg::CNT_STEP; // [R01]
    end else begin
      counter_d = counter_value_word_q;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      counter_value_word_q <= timer_pkg::CNT_RESET;
    end else begin
      counter_value_word_q <= counter_d;
    end
  end

  // Step and wrap mark the cycle in which the counter shows its new value.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      step_q <= 1'b0;
      wrap_q <= 1'b0;
    end else begin
      step_q <= tick & ~counter_clear;
      wrap_q <= overflow_hit;
    end
  end

  // Overflow flag; a new overflow wins over a clear in the same cycle.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      counter_overflow_flag_q <= 1'b0;
    end else if (overflow_hit) begin
      counter_overflow_flag_q <= 1'b1; // [R02]
    end else if (overflow_flag_clear | (vector_read & vec_is_ovf)) begin
      counter_overflow_flag_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channels.

  logic chan1_b_level;
  logic chan1_read_clear;

  assign chan1_b_level = comparator_variant ? comparator_output : channel1_signal_alt_in; // [R06]

  capture_compare_channel u_chan0 (
    .core_clk(core_clk),
    .rstn(rstn),
    .capture_mode(chan_capture_mode[0]),
    .input_select(chan0_input_select),
    .capture_edge(chan0_capture_edge),
    .pwm_mode(chan_pwm_mode[0]),
    .value_load(chan_value_load[0]),
    .value_data(chan_value_data),
    .flag_clear(chan_flag_clear[0]),
    .counter(counter_value_word_q),
    .counter_step(step_q),
    .counter_wrap(wrap_q),
    .input_a(channel0_signal_in), // [R05]
    .input_b(aux_clock), // [R05]
    .value_q(chan0_value_word_q),
    .flag_q(channel_event_flag_q[0]),
    .overrun_q(capture_overrun_q[0]),
    .signal_q(channel0_signal_q)
  );

  capture_compare_channel u_chan1 (
    .core_clk(core_clk),
    .rstn(rstn),
    .capture_mode(chan_capture_mode[1]),
    .input_select(chan1_input_select),
    .capture_edge(chan1_capture_edge),
    .pwm_mode(chan_pwm_mode[1]),
    .value_load(chan_value_load[1]),
    .value_data(chan_value_data),
    .flag_clear(chan_flag_clear[1] | chan1_read_clear),
    .counter(counter_value_word_q),
    .counter_step(step_q),
    .counter_wrap(wrap_q),
    .input_a(channel1_signal_in), // [R06]
    .input_b(chan1_b_level), // [R06]
    .value_q(chan1_value_word_q),
    .flag_q(channel_event_flag_q[1]),
    .overrun_q(capture_overrun_q[1]),
    .signal_q(channel1_signal_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt requests and the shared vector word.

  logic [3:0] vec_d;
  logic chan1_pending;
  logic ovf_pending;

  assign chan1_pending = channel_event_flag_q[1] & chan_irq_enable[1];
  assign ovf_pending = counter_overflow_flag_q & overflow_irq_enable;

  always_comb begin
    if (chan1_pending) begin
      vec_d = timer_pkg::VEC_CHANNEL_ONE; // [R08] [R09]
    end else if (ovf_pending) begin
      vec_d = timer_pkg::VEC_OVERFLOW; // [R08] [R09]
    end else begin
      vec_d = timer_pkg::VEC_NONE;
    end
  end

  function automatic logic vec_shows(input logic [3:0] word, input logic [3:0] code);
    vec_shows = (word == code);
  endfunction

  // Reading the vector word acknowledges the source that it shows.
  assign chan1_read_clear = vector_read
    & vec_shows(timer_vector_word_q, timer_pkg::VEC_CHANNEL_ONE);
  assign vec_is_ovf = vec_shows(timer_vector_word_q, timer_pkg::VEC_OVERFLOW);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      timer_vector_word_q <= timer_pkg::VEC_NONE;
    end else begin
      timer_vector_word_q <= vec_d; // [R09]
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      channel_zero_irq_q <= 1'b0;
      shared_irq_q <= 1'b0;
    end else begin
      channel_zero_irq_q <= channel_event_flag_q[0] & chan_irq_enable[0]; // [R03] [R08]
      shared_irq_q <= chan1_pending | ovf_pending; // [R02] [R03] [R08]
    end
  end

endmodule

// file: timer_pins_model.sv
// Pin-side model: the count clock sources that the timer sees at its pins.
// Assumes one core_clk; every source is a level well inside core_clk timing.
`timescale 1ns/1ps
module timer_pins_model (
  input wire logic core_clk,
  input wire logic rstn,
  output logic ext_timer_clock_pin,
  output logic aux_clock,
  output logic submain_clock
);
  logic [2:0] div_q;
  // Sources toggle every 2, 3 and 1 cycles, so each has its own rate.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      div_q <= 3'h0;
      ext_timer_clock_pin <= 1'h0;
      aux_clock <= 1'h0;
      submain_clock <= 1'h0;
    end else begin
      div_q <= (div_q == 3'h5) ? 3'h0 : div_q + 3'h1;
      if (div_q[0]) ext_timer_clock_pin <= ~ext_timer_clock_pin;
      if (div_q == 3'h2 || div_q == 3'h5) aux_clock <= ~aux_clock;
      submain_clock <= ~submain_clock;
    end
  end
endmodule

// file: timer_two_channel_capture_asserts.sv
// Checker for the two-channel capture/compare timer, bound to its top.
// Assumes one core_clk domain with rstn as its asynchronous reset.
`timescale 1ns/1ps
module timer_two_channel_capture_asserts (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic counter_clear,
  input wire logic overflow_irq_enable,
  input wire logic [1:0] chan_capture_mode,
  input wire timer_pkg::input_sel_t chan0_input_select,
  input wire timer_pkg::edge_sel_t chan0_capture_edge,
  input wire logic channel0_signal_in,
  input wire logic [1:0] chan_irq_enable,
  input wire logic [1:0] chan_flag_clear,
  input wire logic [15:0] counter_value_word_q,
  input wire logic [15:0] chan0_value_word_q,
  input wire logic counter_overflow_flag_q,
  input wire logic [1:0] channel_event_flag_q,
  input wire logic channel_zero_irq_q,
  input wire logic shared_irq_q,
  input wire logic [3:0] timer_vector_word_q
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence s_wrap;
    $past(counter_value_word_q) == 16'hffff && counter_value_word_q == 16'h0000
      && !$past(counter_clear);
  endsequence
  sequence s_rise0;
    chan_capture_mode[0] && chan0_input_select == timer_pkg::IN_A
      && chan0_capture_edge == timer_pkg::EDGE_RISE && $rose(channel0_signal_in);
  endsequence
  a_count_step: assert property (
    counter_value_word_q != $past(counter_value_word_q) |->
      counter_value_word_q == $past(counter_value_word_q) + 16'h0001 || $past(counter_clear))
    else $error("counter moved by other than one step");
  a_clear_zero: assert property (counter_clear |=> counter_value_word_q == 16'h0000)
    else $error("counter not zeroed by clear");
  a_wrap_flag: assert property (s_wrap |-> counter_overflow_flag_q)
    else $error("wrap without overflow flag");
  a_capture_latch: assert property (
    s_rise0 |=> chan0_value_word_q == $past(counter_value_word_q) && channel_event_flag_q[0])
    else $error("capture did not latch counter");
  a_irq0_follow: assert property (
    channel_zero_irq_q == $past(channel_event_flag_q[0] && chan_irq_enable[0]))
    else $error("channel zero request wrong");
  a_shared_irq: assert property (
    shared_irq_q == $past((channel_event_flag_q[1] && chan_irq_enable[1])
      || (counter_overflow_flag_q && overflow_irq_enable)))
    else $error("shared request wrong");
  a_vector_chan1: assert property (
    $past(channel_event_flag_q[1] && chan_irq_enable[1]) |->
      timer_vector_word_q == timer_pkg::VEC_CHANNEL_ONE)
    else $error("vector not channel one");
  a_vector_ovf: assert property (
    $past(counter_overflow_flag_q && overflow_irq_enable && !channel_event_flag_q[1]) |->
      timer_vector_word_q == timer_pkg::VEC_OVERFLOW)
    else $error("vector not overflow");
  a_flag0_hold: assert property (
    $fell(channel_event_flag_q[0]) |-> $past(chan_flag_clear[0]))
    else $error("channel zero flag dropped alone");
endmodule

// file: timer_two_channel_capture_tb.sv
// Self-checking bench for the two-channel capture/compare timer.
// Assumes the pin model supplies the count sources; core_clk is 20 MHz.
`timescale 1ns/1ps
module timer_two_channel_capture_tb;
  logic core_clk = 1'h0;
  logic rstn = 1'h0;
  logic ext_pin, aux, sub, ovf, sig0, sig1, irq0, irqs;
  timer_pkg::clock_sel_t clk_sel = timer_pkg::CLK_EXT_PIN;
  timer_pkg::input_sel_t sel0 = timer_pkg::IN_A;
  timer_pkg::input_sel_t sel1 = timer_pkg::IN_A;
  logic run = 1'h0, clr = 1'h0, ovf_en = 1'h0, variant = 1'h0, vrd = 1'h0;
  logic in0 = 1'h0, in1 = 1'h0, in1b = 1'h0, cmp = 1'h0;
  logic [1:0] cap = 2'h0, load = 2'h0, ien = 2'h0, fclr = 2'h0, pwm = 2'h0, flag, ovr;
  logic [15:0] ldata = 16'h0000, cnt, v0, v1;
  logic [3:0] vec;
  int n_fail = 0;
  int comparisons = 0;
  always #25 core_clk = ~core_clk;
  timer_pins_model i_pins (.core_clk(core_clk), .rstn(rstn), .ext_timer_clock_pin(ext_pin),
    .aux_clock(aux), .submain_clock(sub));
  timer_two_channel_capture i_dut (.core_clk(core_clk), .rstn(rstn),
    .ext_timer_clock_pin(ext_pin), .aux_clock(aux), .submain_clock(sub),
    .clock_select(clk_sel), .count_run(run), .counter_clear(clr),
    .overflow_irq_enable(ovf_en), .overflow_flag_clear(1'h0), .comparator_variant(variant),
    .channel0_signal_in(in0), .channel1_signal_in(in1), .channel1_signal_alt_in(in1b),
    .comparator_output(cmp), .chan_capture_mode(cap), .chan0_input_select(sel0),
    .chan1_input_select(sel1), .chan0_capture_edge(timer_pkg::EDGE_RISE),
    .chan1_capture_edge(timer_pkg::EDGE_RISE), .chan_pwm_mode(pwm),
    .chan_value_load(load), .chan_value_data(ldata), .chan_irq_enable(ien),
    .chan_flag_clear(fclr), .vector_read(vrd), .counter_value_word_q(cnt),
    .chan0_value_word_q(v0), .chan1_value_word_q(v1), .counter_overflow_flag_q(ovf),
    .channel_event_flag_q(flag), .capture_overrun_q(ovr), .channel0_signal_q(sig0),
    .channel1_signal_q(sig1), .channel_zero_irq_q(irq0), .shared_irq_q(irqs),
    .timer_vector_word_q(vec));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t bit got %b exp %b", $time, got, exp);
    end
  endtask
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t word got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic bounded(input logic ok);
    if (ok !== 1'h1) begin
      n_fail++;
      $display("[ERR] %0t wait ran out", $time);
      give_verdict();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Each source counts for 48 cycles; the count must match its rate.
  task automatic t_clock_sel;
    int exp [4] = '{12, 8, 24, 12};
    logic [15:0] held;
    for (int s = 0; s < 4; s++) begin
      tick(1);
      clk_sel <= timer_pkg::clock_sel_t'(s);
      clr <= 1'h1;
      tick(1);
      clr <= 1'h0;
      run <= 1'h1;
      tick(48);
      run <= 1'h0;
      @(negedge core_clk);
      chk_bit(cnt >= exp[s] - 1 && cnt <= exp[s] + 1, 1'h1);
      held = cnt;
      tick(6);
      @(negedge core_clk);
      chk_word(cnt, held);
    end
  endtask
  task automatic t_compare;
    logic s1;
    tick(1);
    clk_sel <= timer_pkg::CLK_EXT_PIN;
    clr <= 1'h1;
    ldata <= 16'h0009;
    load <= 2'h2;
    ien <= 2'h2;
    tick(1);
    clr <= 1'h0;
    load <= 2'h0;
    run <= 1'h1;
    s1 = sig1;
    for (int k = 0; k < 200 && flag[1] !== 1'h1; k++) tick(1);
    bounded(flag[1]);
    run <= 1'h0;
    @(negedge core_clk);
    chk_word(cnt, 16'h0009);
    chk_bit(sig1, ~s1);
    tick(1);
    @(negedge core_clk);
    chk_bit(irqs, 1'h1);
    chk_word({12'h000, vec}, {12'h000, timer_pkg::VEC_CHANNEL_ONE});
    vrd <= 1'h1;
    tick(1);
    vrd <= 1'h0;
    tick(2);
    @(negedge core_clk);
    chk_bit(flag[1], 1'h0);
    chk_bit(irqs, 1'h0);
  endtask
  // Counter is stopped, so a capture must hold exactly its value.
  task automatic t_capture0;
    for (int s = 0; s < 4; s++) begin
      tick(1);
      sel0 <= timer_pkg::input_sel_t'(s);
      cap <= 2'h1;
      ien <= 2'h1;
      tick(2);
      fclr <= 2'h1;
      tick(1);
      fclr <= 2'h0;
      if (s == 0) in0 <= 1'h1;
      tick(8);
      in0 <= 1'h0;
      @(negedge core_clk);
      chk_bit(flag[0], s < 2);
      chk_bit(irq0, s < 2);
      if (s < 2) chk_word(v0, 16'h0009);
    end
    // Two rises on the pin with no clear between them lose the first reading.
    tick(1);
    sel0 <= timer_pkg::IN_A;
    for (int p = 0; p < 2; p++) begin
      tick(2);
      in0 <= 1'h1;
      tick(2);
      in0 <= 1'h0;
      @(negedge core_clk);
      chk_bit(ovr[0], p[0]);
    end
    tick(1);
    fclr <= 2'h1;
    tick(1);
    fclr <= 2'h0;
    @(negedge core_clk);
    chk_bit(ovr[0], 1'h0);
  endtask
  task automatic t_chan1;
    for (int v = 0; v < 2; v++) begin
      tick(1);
      variant <= v[0];
      sel1 <= timer_pkg::IN_B;
      cap <= 2'h2;
      tick(2);
      fclr <= 2'h2;
      tick(1);
      fclr <= 2'h0;
      if (v == 1) in1b <= 1'h1;
      else cmp <= 1'h1;
      tick(3);
      @(negedge core_clk);
      chk_bit(flag[1], 1'h0);
      tick(1);
      if (v == 1) cmp <= 1'h1;
      else in1b <= 1'h1;
      tick(3);
      @(negedge core_clk);
      chk_bit(flag[1], 1'h1);
      chk_word(v1, 16'h0009);
      tick(1);
      cmp <= 1'h0;
      in1b <= 1'h0;
    end
  endtask
  // Full 16-bit run from the fastest source up to the wrap.
  task automatic t_overflow;
    tick(1);
    clk_sel <= timer_pkg::CLK_SUBMAIN;
    clr <= 1'h1;
    ien <= 2'h0;
    pwm <= 2'h1;
    ovf_en <= 1'h1;
    tick(1);
    clr <= 1'h0;
    run <= 1'h1;
    for (int k = 0; k < 140000 && ovf !== 1'h1; k++) tick(1);
    bounded(ovf);
    @(negedge core_clk);
    chk_word(cnt, 16'h0000);
    chk_bit(sig0, 1'h1);
    for (int k = 0; k < 64 && cnt !== 16'h000a; k++) tick(1);
    bounded(cnt === 16'h000a);
    @(negedge core_clk);
    chk_bit(sig0, 1'h0);
    tick(1);
    run <= 1'h0;
    fclr <= 2'h3;
    tick(1);
    fclr <= 2'h0;
    tick(3);
    @(negedge core_clk);
    chk_bit(irqs, 1'h1);
    chk_word({12'h000, vec}, {12'h000, timer_pkg::VEC_OVERFLOW});
    vrd <= 1'h1;
    tick(1);
    vrd <= 1'h0;
    tick(2);
    @(negedge core_clk);
    chk_bit(ovf, 1'h0);
  endtask
  initial begin
    tick(20);
    rstn <= 1'h1;
    tick(2);
    t_clock_sel();
    t_compare();
    t_capture0();
    t_chan1();
    t_overflow();
    give_verdict();
  end
endmodule
bind timer_two_channel_capture timer_two_channel_capture_asserts i_chk (
  .core_clk(core_clk), .rstn(rstn), .counter_clear(counter_clear),
  .overflow_irq_enable(overflow_irq_enable), .chan_capture_mode(chan_capture_mode),
  .chan0_input_select(chan0_input_select), .chan0_capture_edge(chan0_capture_edge),
  .channel0_signal_in(channel0_signal_in), .chan_irq_enable(chan_irq_enable),
  .chan_flag_clear(chan_flag_clear), .counter_value_word_q(counter_value_word_q),
  .chan0_value_word_q(chan0_value_word_q), .counter_overflow_flag_q(counter_overflow_flag_q),
  .channel_event_flag_q(channel_event_flag_q), .channel_zero_irq_q(channel_zero_irq_q),
  .shared_irq_q(shared_irq_q), .timer_vector_word_q(timer_vector_word_q));
